// File: rtl/sdic_pkg.sv
// package: constants shared by both ends of the serial converter link, and the code conversion function used by the converter end
package sdic_pkg;
  localparam int CODE_W = 12;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  // output step in microvolts per code
  localparam int STEP_UV = 1000;
  // host serial clock: half period in ns, then in mclk cycles (32 ns period)
  localparam int HALF_PERIOD_NS = 16;
  localparam int MCLK_NS = 4;
  localparam logic [3:0] HALF_CYC = 4'(HALF_PERIOD_NS / MCLK_NS);
  localparam logic [3:0] BITCNT_RESET = 4'h0;
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic [3:0] BITS_LAST = 4'(CODE_W - 1);
  // output millivolts for a code
  function automatic logic [11:0] code_to_mv(input logic [11:0] code);
    code_to_mv = 12'((int'(code) * STEP_UV) / 1000);
  endfunction
endpackage

// File: rtl/sdic_link_if.sv
// interface: serial link between host and converter
`timescale 1ns/1ps
`default_nettype none
interface sdic_link_if;
  logic serialClk;
  logic serial_in_line;
  logic selectN;
  logic load_strobe_n;
  logic zero_clear_n;
  modport device (input serialClk, serial_in_line, selectN, load_strobe_n,
    zero_clear_n);
  modport host (output serialClk, serial_in_line, selectN, load_strobe_n,
    zero_clear_n);
endinterface
`default_nettype wire

// File: rtl/sdic_device.sv
// module: converter end, input shift register and converter register
`timescale 1ns/1ps
`default_nettype none
module sdic_device
  import sdic_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  sdic_link_if.device link,
  output logic [11:0] dacCode,
  output logic [11:0] outputMv
);
  import sdic_pkg::*;

  typedef struct packed {
    logic [2:0] clkSync;
    logic [2:0] csSync;
    logic [1:0] dinSync;
    logic [1:0] ldSync;
    logic [1:0] clrSync;
    logic [11:0] shift;
    logic [11:0] code;
    logic [11:0] mv;
  } sdic_dev_t;

  sdic_dev_t st;
  sdic_dev_t next_st;
  logic clkRise;
  logic csRise;
  logic shiftEv;
  logic [11:0] next_shift;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.clkSync = {st.clkSync[1:0], link.serialClk};
    next_st.csSync = {st.csSync[1:0], link.selectN};
    next_st.dinSync = {st.dinSync[0], link.serial_in_line};
    next_st.ldSync = {st.ldSync[0], link.load_strobe_n};
    next_st.clrSync = {st.clrSync[0], link.zero_clear_n};
    // the two strobes are interchangeable: either rises while other low
    clkRise = st.clkSync[1] & ~st.clkSync[2] & ~st.csSync[1];
    csRise = st.csSync[1] & ~st.csSync[2] & ~st.clkSync[1];
    shiftEv = clkRise | csRise;
    // msb first: older bits move up, excess fall off the top
    next_shift = {st.shift[10:0], st.dinSync[1]};
    if (shiftEv) begin
      next_st.shift = next_shift;
    end
    if (!st.clrSync[1]) begin
      next_st.code = CODE_RESET;
    end else if (!st.ldSync[1] && st.csSync[1]) begin
      // level sensitive: transparent while load low and select high
      next_st.code = st.shift;
    end
    next_st.mv = code_to_mv(next_st.code);
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{clkSync: 3'h0, csSync: 3'h7, dinSync: 2'h0, ldSync: 2'h3,
        clrSync: 2'h3, shift: CODE_RESET, code: CODE_RESET,
        mv: CODE_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign dacCode = st.code;
  assign outputMv = st.mv;
endmodule
`default_nettype wire

// File: rtl/sdic_host.sv
// module: host end, shifts a code out and strobes load
`timescale 1ns/1ps
`default_nettype none
module sdic_host
  import sdic_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  sdic_link_if.host link,
  input wire logic writeValid,
  input wire logic [11:0] writeCode,
  output logic writeReady,
  input wire logic clearReq,
  output logic writeDone
);
  import sdic_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_LOW = 5'b00010,
    S_HIGH = 5'b00100,
    S_DESEL = 5'b01000,
    S_LOAD = 5'b10000
  } sdic_state_t;

  typedef struct packed {
    sdic_state_t state;
    logic [3:0] div;
    logic [3:0] bitCnt;
    logic [11:0] data;
    logic sclk;
    logic sdo;
    logic csN;
    logic ldN;
    logic clrN;
    logic done;
  } sdic_host_t;

  sdic_host_t st;
  sdic_host_t next_st;
  logic tick;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.clrN = ~clearReq;
    tick = (st.div == HALF_CYC - 4'h1);
    next_st.div = (st.state == S_IDLE || tick) ? DIV_RESET : st.div + 4'h1;
    unique case (st.state)
      S_IDLE: begin
        if (writeValid) begin
          next_st.data = writeCode;
          next_st.bitCnt = BITCNT_RESET;
          next_st.csN = 1'b0;
          next_st.sdo = writeCode[11];
          next_st.state = S_LOW;
        end
      end
      S_LOW: begin
        if (tick) begin
          next_st.sclk = 1'b1;
          next_st.state = S_HIGH;
        end
      end
      S_HIGH: begin
        // deselect while the clock is still high: a rising select with the
        // clock low would shift one bit too many and push the msb out
        if (st.bitCnt == BITS_LAST && st.div == DIV_RESET) begin
          next_st.csN = 1'b1;
        end
        if (tick) begin
          next_st.sclk = 1'b0;
          next_st.data = {st.data[10:0], 1'b0};
          next_st.sdo = st.data[10];
          if (st.bitCnt == BITS_LAST) begin
            next_st.csN = 1'b1;
            next_st.state = S_DESEL;
          end else begin
            next_st.bitCnt = st.bitCnt + 4'h1;
            next_st.state = S_LOW;
          end
        end
      end
      S_DESEL: begin
        if (tick) begin
          next_st.ldN = 1'b0;
          next_st.state = S_LOAD;
        end
      end
      S_LOAD: begin
        if (tick) begin
          // load returns high before any further shifting
          next_st.ldN = 1'b1;
          next_st.done = 1'b1;
          next_st.state = S_IDLE;
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{state: S_IDLE, div: DIV_RESET, bitCnt: BITCNT_RESET,
        data: CODE_RESET, sclk: 1'b0, sdo: 1'b0, csN: 1'b1, ldN: 1'b1,
        clrN: 1'b1, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign writeReady = (st.state == S_IDLE);
  assign writeDone = st.done;
  assign link.serialClk = st.sclk;
  assign link.serial_in_line = st.sdo;
  assign link.selectN = st.csN;
  assign link.load_strobe_n = st.ldN;
  assign link.zero_clear_n = st.clrN;
endmodule
`default_nettype wire

// File: test/sdic_props.sv
// checker: link timing and converter register
`timescale 1ns/1ps
`default_nettype none
module sdic_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic load_strobe_n,
  input wire logic zero_clear_n,
  input wire logic [11:0] dacCode,
  input wire logic [11:0] outputMv
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence halfBit;
    serialClk[*4] ##1 !serialClk;
  endsequence
  sequence loadSoon;
    ##[1:8] $fell(load_strobe_n);
  endsequence
  clr_zero_a: assert property (
    $fell(zero_clear_n) |-> ##[1:4] dacCode == 12'h000) else $error("late");
  hold_zero_a: assert property (
    !zero_clear_n[*4] |-> dacCode == 12'h000) else $error("not zero");
  mv_track_a: assert property (
    outputMv == dacCode) else $error("mv off");
  clk_sel_a: assert property (
    $rose(serialClk) |-> !selectN) else $error("clock unselected");
  half_bit_a: assert property (
    $rose(serialClk) |-> halfBit) else $error("half bit");
  frame_start_a: assert property (
    $fell(selectN) |-> !serialClk[*4] ##1 serialClk) else $error("start");
  ld_idle_a: assert property (
    !load_strobe_n |-> selectN && !serialClk) else $error("load busy");
  ld_frame_a: assert property (
    $rose(selectN) |-> loadSoon) else $error("no load");
endmodule
`default_nettype wire

// File: test/sdic_tb.sv
// bench: host end drives device end over the link
`timescale 1ns/1ps
`default_nettype none
module sdic_tb;
  import sdic_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0;
  logic writeValid = 1'b0, clearReq = 1'b0;
  logic [11:0] writeCode = 12'h000;
  logic [11:0] rnd = 12'h04F;
  logic writeReady, writeDone;
  logic [11:0] dacCode, outputMv, last;
  int miscompares = 0, n_checks = 0;
  sdic_link_if link();
  sdic_host u_sdic_host (.mclk(mclk), .reset_n(reset_n), .link(link),
    .writeValid(writeValid), .writeCode(writeCode), .writeReady(writeReady),
    .clearReq(clearReq), .writeDone(writeDone));
  sdic_device u_sdic_device (.mclk(mclk), .reset_n(reset_n), .link(link),
    .dacCode(dacCode), .outputMv(outputMv));
  sdic_props u_sdic_props (.mclk(mclk), .reset_n(reset_n),
    .serialClk(link.serialClk), .selectN(link.selectN),
    .load_strobe_n(link.load_strobe_n), .zero_clear_n(link.zero_clear_n),
    .dacCode(dacCode), .outputMv(outputMv));
  always #2 mclk = ~mclk;
  function automatic logic [11:0] lfsr(input logic [11:0] s);
    return {s[10:0], s[11] ^ s[10] ^ s[9] ^ s[3]};
  endfunction
  // twelve bits msb first: the register ends holding the code sent
  function automatic logic [11:0] expect_code(input logic [11:0] c);
    return c;
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic send(input logic [11:0] c);
    int i;
    last = dacCode;
    @(posedge mclk);
    writeValid <= 1'b1;
    writeCode <= c;
    @(posedge mclk);
    writeValid <= 1'b0;
    repeat (40) @(negedge mclk);
    check(dacCode, last);
    for (i = 0; i < 200 && writeDone !== 1'b1; i++) @(negedge mclk);
    if (i == 200) begin
      miscompares++;
      complete_run();
    end
    check({10'h000, writeReady, link.load_strobe_n}, 12'h003);
    repeat (6) @(negedge mclk);
    check(dacCode, expect_code(c));
    check(outputMv, expect_code(c));
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    send(CODE_FULL);
    @(posedge mclk);
    clearReq <= 1'b1;
    repeat (6) @(negedge mclk);
    check(dacCode, CODE_RESET);
    @(posedge mclk);
    clearReq <= 1'b0;
    repeat (8) @(negedge mclk);
    check(dacCode, CODE_RESET);
    send(12'h800);
    send(12'h7FF);
    send(CODE_RESET);
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      send(rnd);
    end
    complete_run();
  end
endmodule
`default_nettype wire
